// [hdl/seq_pkg.sv]
// Function
// - light load voltage cut, 100% halves
// - 1.8x current for high torque window
// - programmable start delay before ramping
// - five start delay modes, default coast
// - mode 0: static hold voltage
// - mode 1: DC brake voltage
// - mode 2: inverter off
// - mode 3: start frequency clockwise, initial voltage
// - mode 4: reference direction, zero ref 0 Hz
// - stop mode: coast or static hold
// - stop action below threshold or at 0 Hz
// - stop threshold 0.1 to 10 Hz
// - DC brake voltage 0 to 100 percent
// - input function 5 falling edge brakes
// - stop plus below cut-in starts braking
// - brake held 0 to 60 s
// - threshold above start frequency skips delay
// - static hold high threshold: frequency jumps
// - cut-in zero disables stop braking
// - start frequency 0 to 10 Hz
package seq_pkg;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 20;
    localparam int TICK_PERIOD_MS = 100;
    localparam int TICK_CYCLES_DEF = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
    localparam logic [12:0] TICKS_PER_S = 13'h000A;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_REF = 8'h04;
    localparam logic [7:0] OFS_START_CFG = 8'h08;
    localparam logic [7:0] OFS_STOP_CFG = 8'h0C;
    localparam logic [7:0] OFS_DC_CFG = 8'h10;
    localparam logic [7:0] OFS_START_FV = 8'h14;
    localparam logic [7:0] OFS_RESON = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;

    // ****************************************
    // values and limits
    // ****************************************
    localparam logic [6:0] PCT_FULL = 7'h64;
    localparam logic [6:0] DELAY_MAX = 7'h64;
    localparam logic [2:0] HT_MAX = 3'h5;
    localparam logic [7:0] THR_MIN = 8'h01;
    localparam logic [7:0] THR_MAX = 8'h64;
    localparam logic [5:0] BRAKE_S_MAX = 6'h3C;
    localparam logic [6:0] START_F_MAX = 7'h64;
    localparam logic [11:0] INIT_V_MAX = 12'h7D0;
    localparam logic [2:0] MODE_MAX = 3'h4;
    localparam logic [2:0] DI_FUNC_BRAKE_INV = 3'h5;
    localparam logic [10:0] CURR_NOMINAL_PM = 11'h3E8;
    localparam logic [10:0] CURR_HIGH_PM = 11'h708;
    localparam logic [15:0] RESO_DIV = 16'h00C8;

    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_DELAY = 6'b000010,
        ST_RUN = 6'b000100,
        ST_STOP_RAMP = 6'b001000,
        ST_STOP_FN = 6'b010000,
        ST_BRAKE = 6'b100000
    } seq_e;

    typedef enum logic [2:0] {
        SD_HOLD = 3'h0,
        SD_BRAKE = 3'h1,
        SD_COAST = 3'h2,
        SD_FIXED_CW = 3'h3,
        SD_REF_DIR = 3'h4
    } start_mode_e;

    typedef struct packed {
        logic [6:0] start_delay;
        logic [2:0] start_mode;
        logic [2:0] ht_time;
        logic [7:0] stop_thr;
        logic stop_hold;
        logic [15:0] cutin;
        logic [6:0] brake_pct;
        logic [6:0] hold_pct;
        logic [5:0] brake_s;
        logic [2:0] di_func;
        logic [6:0] start_f;
        logic [11:0] init_v;
        logic [6:0] reso;
    } cfg_s;

    localparam cfg_s CFG_RST = '{
        start_delay: 7'h00, start_mode: 3'h2, ht_time: 3'h0, stop_thr: 8'h01, stop_hold: 1'b0,
        cutin: 16'h0000, brake_pct: 7'h00, hold_pct: 7'h00, brake_s: 6'h0A, di_func: 3'h0,
        start_f: 7'h00, init_v: 12'h000, reso: 7'h00
    };

endpackage

// [hdl/tick_if.sv]
`timescale 1ns/1ps
interface tick_if;
    logic tick;
    modport src (output tick);
    modport dst (input tick);
endinterface // tick_if

// [hdl/tick_divider.sv]
`timescale 1ns/1ps
module tick_divider #(
    parameter int TICK_CYCLES = seq_pkg::TICK_CYCLES_DEF
) (
    input wire logic clk,
    input wire logic rst,
    tick_if.src tk
);
    import seq_pkg::*;

    typedef struct packed {
        logic [22:0] cnt;
        logic tick;
    } div_s;

    div_s q;
    div_s d;

    // ****************************************
    // one-cycle enable every tick period
    // ****************************************
    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (q.cnt == 23'(TICK_CYCLES - 1)) begin
            d.cnt = 23'h000000;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt + 23'h000001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tk.tick = q.tick;
endmodule // tick_divider

// [hdl/start_stop_seq.sv]
`timescale 1ns/1ps
module start_stop_seq #(
    parameter int TICK_CYCLES = seq_pkg::TICK_CYCLES_DEF
) (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [15:0] OUT_FREQ,
    input wire logic [6:0] LOAD_PCT,
    input wire logic DI_PIN,
    output logic INV_ON,
    output logic RAMP_RUN,
    output logic [15:0] RAMP_TARGET,
    output logic FREQ_FORCE,
    output logic FREQ_JUMP,
    output logic [15:0] FREQ_SET,
    output logic DIR_REV,
    output logic [11:0] VOLT_SET,
    output logic [6:0] VOLT_SCALE,
    output logic DC_ON,
    output logic [6:0] DC_LEVEL,
    output logic HIGH_TORQUE,
    output logic [10:0] CURR_LIMIT_PM
);
    import seq_pkg::*;

    typedef struct packed {
        seq_e st;
        logic [12:0] timer;
        cfg_s cfg;
        cfg_s act;
        logic start;
        logic rev;
        logic [15:0] ref_f;
        logic [2:0] di_sync;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
        logic inv_on;
        logic ramp_run;
        logic [15:0] ramp_target;
        logic force_en;
        logic freq_jump;
        logic [15:0] freq_set;
        logic dir_rev;
        logic [11:0] volt_set;
        logic [6:0] volt_scale;
        logic dc_on;
        logic [6:0] dc_level;
        logic high_torque;
        logic [10:0] curr_lim;
    } seq_s;

    seq_s q;
    seq_s d;

    tick_if tk ();

    tick_divider #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_div (
        .clk(REF_CLK),
        .rst(RST),
        .tk(tk)
    );

    function automatic logic [6:0] clamp7(input logic [6:0] v, input logic [6:0] mx);
        clamp7 = (v > mx) ? mx : v;
    endfunction

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic setup;
        logic access;
        logic di_fall;
        logic skip_delay;
        logic [15:0] thr16;
        logic [15:0] prod;
        logic [6:0] load;
        logic [12:0] brake_ticks;
        seq_e nxt;
        setup = 1'b0;
        access = 1'b0;
        di_fall = 1'b0;
        skip_delay = 1'b0;
        thr16 = 16'h0000;
        prod = 16'h0000;
        load = 7'h00;
        brake_ticks = 13'h0000;
        nxt = q.st;
        d = q;

        // ****************************************
        // APB slave, one wait state
        // ****************************************
        setup = PSEL && PENABLE && !q.pready;
        access = PSEL && PENABLE && q.pready;
        d.pready = setup;
        if (setup) begin
            d.pslverr = 1'b0;
            unique case (PADDR)
                OFS_CTRL: d.prdata = {30'h00000000, q.rev, q.start};
                OFS_REF: d.prdata = {16'h0000, q.ref_f};
                OFS_START_CFG: d.prdata = {13'h0000, q.cfg.ht_time, 5'h00, q.cfg.start_mode, 1'b0, q.cfg.start_delay};
                OFS_STOP_CFG: d.prdata = {q.cfg.cutin, 7'h00, q.cfg.stop_hold, q.cfg.stop_thr};
                OFS_DC_CFG: d.prdata = {5'h00, q.cfg.di_func, 2'h0, q.cfg.brake_s, 1'b0, q.cfg.hold_pct,
                                        1'b0, q.cfg.brake_pct};
                OFS_START_FV: d.prdata = {4'h0, q.cfg.init_v, 9'h000, q.cfg.start_f};
                OFS_RESON: d.prdata = {25'h0000000, q.cfg.reso};
                OFS_STATUS: d.prdata = {21'h000000, q.high_torque, q.dc_on, q.inv_on, 2'h0, q.st};
                default: begin
                    d.prdata = 32'h00000000;
                    d.pslverr = 1'b1;
                end
            endcase
        end
        if (access && PWRITE) begin
            unique case (PADDR)
                OFS_CTRL: begin
                    d.start = PWDATA[0];
                    d.rev = PWDATA[1];
                end
                OFS_REF: d.ref_f = PWDATA[15:0];
                OFS_START_CFG: begin
                    d.cfg.start_delay = clamp7(PWDATA[6:0], DELAY_MAX);
                    d.cfg.start_mode = (PWDATA[10:8] > MODE_MAX) ? MODE_MAX : PWDATA[10:8];
                    d.cfg.ht_time = (PWDATA[18:16] > HT_MAX) ? HT_MAX : PWDATA[18:16];
                end
                OFS_STOP_CFG: begin
                    d.cfg.stop_thr = (PWDATA[7:0] < THR_MIN) ? THR_MIN :
                                     (PWDATA[7:0] > THR_MAX) ? THR_MAX : PWDATA[7:0];
                    d.cfg.stop_hold = PWDATA[8];
                    d.cfg.cutin = PWDATA[31:16];
                end
                OFS_DC_CFG: begin
                    d.cfg.brake_pct = clamp7(PWDATA[6:0], PCT_FULL);
                    d.cfg.hold_pct = clamp7(PWDATA[14:8], PCT_FULL);
                    d.cfg.brake_s = (PWDATA[21:16] > BRAKE_S_MAX) ? BRAKE_S_MAX : PWDATA[21:16];
                    d.cfg.di_func = PWDATA[26:24];
                end
                OFS_START_FV: begin
                    d.cfg.start_f = clamp7(PWDATA[6:0], START_F_MAX);
                    d.cfg.init_v = (PWDATA[27:16] > INIT_V_MAX) ? INIT_V_MAX : PWDATA[27:16];
                end
                OFS_RESON: d.cfg.reso = clamp7(PWDATA[6:0], PCT_FULL);
                default: begin
                end
            endcase
        end

        // ****************************************
        // input pin sync and edge
        // ****************************************
        d.di_sync = {q.di_sync[1:0], DI_PIN};
        // function code is live while idle, the sampled copy during a sequence
        di_fall = q.di_sync[2] && !q.di_sync[1] &&
                  (((q.st == ST_IDLE) ? q.cfg.di_func : q.act.di_func) == DI_FUNC_BRAKE_INV);

        // ****************************************
        // sequencer
        // ****************************************
        thr16 = {8'h00, q.act.stop_thr};
        brake_ticks = 13'(q.act.brake_s) * TICKS_PER_S;
        d.freq_jump = 1'b0;
        if (tk.tick && (q.timer != 13'h1FFF)) begin
            d.timer = q.timer + 13'h0001;
        end
        if (di_fall && (q.st != ST_BRAKE)) begin
            nxt = ST_BRAKE;
            d.act = q.cfg;
        end else begin
            unique case (q.st)
                ST_IDLE, ST_STOP_FN: begin
                    if (q.start && ((q.st == ST_IDLE) || (q.ref_f >= {8'h00, q.cfg.stop_thr}))) begin
                        d.act = q.cfg;
                        skip_delay = ({1'b0, q.cfg.start_f} < q.cfg.stop_thr);
                        if (skip_delay || (q.cfg.start_delay == 7'h00)) begin
                            nxt = ST_RUN;
                            d.freq_jump = skip_delay && q.cfg.stop_hold;
                            d.freq_set = {8'h00, q.cfg.stop_thr};
                        end else begin
                            nxt = ST_DELAY;
                        end
                    end
                end
                ST_DELAY: begin
                    if (!q.start) begin
                        nxt = ST_IDLE;
                    end else if (q.timer >= 13'(q.act.start_delay)) begin
                        nxt = ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (!q.start) begin
                        nxt = ST_STOP_RAMP;
                        d.act = q.cfg;
                    end else if ((q.ref_f < thr16) && (OUT_FREQ < thr16)) begin
                        nxt = ST_STOP_FN;
                    end
                end
                ST_STOP_RAMP: begin
                    if (q.start) begin
                        nxt = ST_RUN;
                    end else if ((q.act.cutin != 16'h0000) && (OUT_FREQ < q.act.cutin)) begin
                        nxt = ST_BRAKE;
                    end else if ((OUT_FREQ < thr16) || (OUT_FREQ == 16'h0000)) begin
                        nxt = ST_STOP_FN;
                    end
                end
                ST_BRAKE: begin
                    if (q.timer >= brake_ticks) begin
                        nxt = ST_IDLE;
                    end
                end
            endcase
        end
        if (nxt != q.st) begin
            d.timer = 13'h0000;
        end
        d.st = nxt;

        // ****************************************
        // outputs from the next state
        // ****************************************
        d.inv_on = 1'b0;
        d.ramp_run = 1'b0;
        d.ramp_target = 16'h0000;
        d.force_en = 1'b0;
        d.dc_on = 1'b0;
        d.dc_level = 7'h00;
        d.dir_rev = q.rev;
        d.volt_set = 12'h000;
        d.high_torque = 1'b0;
        if (!d.freq_jump) begin
            d.freq_set = 16'h0000;
        end
        unique case (nxt)
            ST_IDLE: begin
            end
            ST_DELAY: begin
                unique case (q.st == ST_DELAY ? q.act.start_mode : q.cfg.start_mode)
                    SD_HOLD: begin
                        d.inv_on = 1'b1;
                        d.dc_on = 1'b1;
                        d.dc_level = (q.st == ST_DELAY) ? q.act.hold_pct : q.cfg.hold_pct;
                    end
                    SD_BRAKE: begin
                        d.inv_on = 1'b1;
                        d.dc_on = 1'b1;
                        d.dc_level = (q.st == ST_DELAY) ? q.act.brake_pct : q.cfg.brake_pct;
                    end
                    SD_FIXED_CW: begin
                        d.inv_on = 1'b1;
                        d.force_en = 1'b1;
                        d.dir_rev = 1'b0;
                        d.freq_set = {9'h000, d.act.start_f};
                        d.volt_set = d.act.init_v;
                    end
                    SD_REF_DIR: begin
                        d.inv_on = 1'b1;
                        d.force_en = 1'b1;
                        d.freq_set = (q.ref_f == 16'h0000) ? 16'h0000 : {9'h000, d.act.start_f};
                        d.volt_set = d.act.init_v;
                    end
                    default: begin
                        d.inv_on = 1'b0;
                    end
                endcase
            end
            ST_RUN: begin
                d.inv_on = 1'b1;
                d.ramp_run = 1'b1;
                d.ramp_target = q.ref_f;
                d.high_torque = (d.timer < 13'(q.act.ht_time)) ||
                                ((q.st != ST_RUN) && (q.cfg.ht_time != 3'h0));
            end
            ST_STOP_RAMP: begin
                d.inv_on = 1'b1;
                d.ramp_run = 1'b1;
            end
            ST_STOP_FN: begin
                d.inv_on = q.act.stop_hold;
                d.dc_on = q.act.stop_hold;
                d.dc_level = q.act.stop_hold ? q.act.hold_pct : 7'h00;
            end
            ST_BRAKE: begin
                d.inv_on = 1'b1;
                d.dc_on = 1'b1;
                d.dc_level = (q.st == ST_BRAKE) ? q.act.brake_pct : q.cfg.brake_pct;
            end
        endcase
        d.curr_lim = d.high_torque ? CURR_HIGH_PM : CURR_NOMINAL_PM;

        // ****************************************
        // resonance voltage reduction
        // ****************************************
        load = (LOAD_PCT > PCT_FULL) ? PCT_FULL : LOAD_PCT;
        prod = 16'(q.act.reso) * 16'(PCT_FULL - load);
        d.volt_scale = PCT_FULL - 7'(prod / RESO_DIV);
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            q <= '0;
            q.st <= ST_IDLE;
            q.cfg <= CFG_RST;
            q.act <= CFG_RST;
            q.volt_scale <= PCT_FULL;
            q.curr_lim <= CURR_NOMINAL_PM;
        end else begin
            q <= d;
        end
    end

    assign PRDATA = q.prdata;
    assign PREADY = q.pready;
    assign PSLVERR = q.pslverr;
    assign INV_ON = q.inv_on;
    assign RAMP_RUN = q.ramp_run;
    assign RAMP_TARGET = q.ramp_target;
    assign FREQ_FORCE = q.force_en;
    assign FREQ_JUMP = q.freq_jump;
    assign FREQ_SET = q.freq_set;
    assign DIR_REV = q.dir_rev;
    assign VOLT_SET = q.volt_set;
    assign VOLT_SCALE = q.volt_scale;
    assign DC_ON = q.dc_on;
    assign DC_LEVEL = q.dc_level;
    assign HIGH_TORQUE = q.high_torque;
    assign CURR_LIMIT_PM = q.curr_lim;
endmodule // start_stop_seq

// [dv/seq_assertions.sv]
`timescale 1ns/1ps
module seq_checker
    import seq_pkg::*;
#(
    parameter int TICK_CYCLES = 10
) (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PREADY,
    input wire logic [6:0] LOAD_PCT,
    input wire logic RAMP_RUN,
    input wire logic [15:0] RAMP_TARGET,
    input wire logic FREQ_FORCE,
    input wire logic [6:0] VOLT_SCALE,
    input wire logic HIGH_TORQUE,
    input wire logic [10:0] CURR_LIMIT_PM
);
    // ****
    // helper: length of the high torque window
    // ****
    // longest window plus one tick of phase slack
    localparam int HT_LIM = (int'(HT_MAX) + 1) * TICK_CYCLES;
    logic [31:0] ht_cnt_q;

    always_ff @(posedge REF_CLK) begin
        if (RST || !HIGH_TORQUE) begin
            ht_cnt_q <= 32'h00000000;
        end else begin
            ht_cnt_q <= ht_cnt_q + 32'h00000001;
        end
    end

    // ****
    // properties
    // ****
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);

    sequence s_access;
        PSEL && PENABLE && !PREADY;
    endsequence
    sequence s_answer;
        PREADY ##1 !PREADY;
    endsequence

    a_apb_one_wait: assert property (s_access |=> s_answer)
        else $error("ready not one cycle after access");
    a_curr_limit_map: assert property (CURR_LIMIT_PM == (HIGH_TORQUE ? CURR_HIGH_PM : CURR_NOMINAL_PM))
        else $error("current limit does not follow high torque");
    a_torque_with_ramp: assert property ($rose(HIGH_TORQUE) |-> RAMP_RUN)
        else $error("high torque began outside run");
    a_torque_window_max: assert property (ht_cnt_q <= 32'(HT_LIM))
        else $error("high torque window too long");
    a_scale_range: assert property (VOLT_SCALE >= 7'h32 && VOLT_SCALE <= PCT_FULL)
        else $error("voltage scale out of range");
    a_full_load_scale: assert property (LOAD_PCT >= PCT_FULL [*3] |-> VOLT_SCALE == PCT_FULL)
        else $error("voltage cut at full load");
    a_force_no_ramp: assert property (FREQ_FORCE |-> !RAMP_RUN && RAMP_TARGET == 16'h0000)
        else $error("ramp active while start delay forces frequency");
    a_target_in_run: assert property (RAMP_TARGET != 16'h0000 |-> RAMP_RUN)
        else $error("ramp target without ramp run");
endmodule // seq_checker

bind start_stop_seq seq_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
    .REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .LOAD_PCT(LOAD_PCT),
    .RAMP_RUN(RAMP_RUN), .RAMP_TARGET(RAMP_TARGET), .FREQ_FORCE(FREQ_FORCE), .VOLT_SCALE(VOLT_SCALE),
    .HIGH_TORQUE(HIGH_TORQUE), .CURR_LIMIT_PM(CURR_LIMIT_PM)
);

// [dv/inv_stage_model.sv]
`timescale 1ns/1ps
module inv_stage_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic inv_on,
    input wire logic ramp_run,
    input wire logic [15:0] ramp_target,
    input wire logic freq_force,
    input wire logic freq_jump,
    input wire logic [15:0] freq_set,
    output logic [15:0] out_freq
);
    logic [15:0] goal;

    // ramps one step a cycle; a coasting stage reports no output frequency
    assign goal = ramp_run ? ramp_target : 16'h0000;
    always_ff @(posedge clk) begin
        if (rst || !inv_on) begin
            out_freq <= 16'h0000;
        end else if (freq_force || freq_jump) begin
            out_freq <= freq_set;
        end else if (out_freq < goal) begin
            out_freq <= out_freq + 16'h0001;
        end else if (out_freq > goal) begin
            out_freq <= out_freq - 16'h0001;
        end
    end
endmodule // inv_stage_model

// [dv/start_stop_seq_bench.sv]
`timescale 1ns/1ps
module start_stop_seq_bench;
    import seq_pkg::*;
    localparam int TC = 10;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, di_pin = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000, prdata;
    logic [6:0] load_pct = 7'h00, volt_scale, dc_level;
    logic pready, pslverr, inv_on, ramp_run, freq_force, freq_jump, dir_rev, dc_on, high_torque;
    logic [15:0] out_freq, ramp_target, freq_set, jump_f;
    logic [11:0] volt_set;
    logic [10:0] curr_limit;
    int n_errors = 0, n_tests = 0, cyc = 0, jumps = 0;

    start_stop_seq #(.TICK_CYCLES(TC)) dut_u (
        .REF_CLK(ref_clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .OUT_FREQ(out_freq),
        .LOAD_PCT(load_pct), .DI_PIN(di_pin), .INV_ON(inv_on), .RAMP_RUN(ramp_run), .RAMP_TARGET(ramp_target),
        .FREQ_FORCE(freq_force), .FREQ_JUMP(freq_jump), .FREQ_SET(freq_set), .DIR_REV(dir_rev),
        .VOLT_SET(volt_set), .VOLT_SCALE(volt_scale), .DC_ON(dc_on), .DC_LEVEL(dc_level),
        .HIGH_TORQUE(high_torque), .CURR_LIMIT_PM(curr_limit)
    );
    inv_stage_model model_u (
        .clk(ref_clk), .rst(rst), .inv_on(inv_on), .ramp_run(ramp_run), .ramp_target(ramp_target),
        .freq_force(freq_force), .freq_jump(freq_jump), .freq_set(freq_set), .out_freq(out_freq)
    );

    initial begin
        forever #10 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (freq_jump === 1'b1) begin
            jumps <= jumps + 1;
            jump_f <= freq_set;
        end
    end

    // ****
    // tasks
    // ****
    task automatic summarize();
        if (n_errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h00000000, q, e);
        chk($sformatf("reg %h", a), q, x);
    endtask

    task automatic wait_st(input logic [5:0] s);
        logic [31:0] q;
        logic e;
        int k;
        k = 0;
        do begin
            apb(1'b0, OFS_STATUS, 32'h00000000, q, e);
            k++;
        end while (q[5:0] !== s && k < 400);
        chk("state", q[5:0], s);
    endtask

    task automatic wait_run();
        int k;
        k = 0;
        while (ramp_run !== 1'b1 && k < 300) begin
            @(posedge ref_clk);
            k++;
        end
        chk("ramp_run", ramp_run, 32'h00000001);
    endtask

    // ****
    // tests
    // ****
    initial begin
        logic [31:0] q;
        logic e;
        int t0;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        chk("volt_scale", volt_scale, 32'h00000064);
        rd(OFS_START_CFG, 32'h00000200);
        rd(OFS_STOP_CFG, 32'h00000001);
        rd(OFS_DC_CFG, 32'h000A0000);
        rd(OFS_START_FV, 32'h00000000);
        apb(1'b0, 8'h20, 32'h00000000, q, e);
        chk("slverr", e, 32'h00000001);
        wr(OFS_START_CFG, 32'h0007007F);
        rd(OFS_START_CFG, 32'h00050064);
        wr(OFS_STOP_CFG, 32'h000000C8);
        rd(OFS_STOP_CFG, 32'h00000064);
        wr(OFS_START_FV, 32'h01000014);
        wr(OFS_DC_CFG, 32'h00011E28);
        wr(OFS_REF, 32'h00000064);
        for (int m = 0; m < 5; m++) begin
            wr(OFS_STOP_CFG, 32'h00000001 | 32'(m % 2) << 8);
            wr(OFS_START_CFG, 32'h00030005 | 32'(m) << 8);
            wr(OFS_CTRL, 32'h00000003);
            t0 = cyc;
            repeat (3) @(posedge ref_clk);
            chk("inv_on", inv_on, m != 2);
            chk("dc_on", dc_on, m < 2);
            if (m < 2) begin
                chk("dc_level", dc_level, m == 1 ? 32'h00000028 : 32'h0000001E);
            end
            if (m > 2) begin
                chk("force", freq_force, 32'h00000001);
                chk("freq_set", freq_set, 32'h00000014);
                chk("volt_set", volt_set, 32'h00000100);
                chk("dir_rev", dir_rev, m == 4);
            end
            wait_run();
            chk("delay", (cyc - t0) inside {[38:54]}, 32'h00000001);
            chk("torque", high_torque, 32'h00000001);
            chk("curr_lim", curr_limit, 32'h00000708);
            chk("target", ramp_target, 32'h00000064);
            repeat (120) @(posedge ref_clk);
            chk("torque_end", high_torque, 32'h00000000);
            wr(OFS_CTRL, 32'h00000000);
            wait_st(6'h10);
            chk("stop_dc", dc_on, m % 2);
        end
        // cut-in braking after a stop, no start delay
        wr(OFS_START_CFG, 32'h00000200);
        wr(OFS_STOP_CFG, 32'h00320001);
        wr(OFS_CTRL, 32'h00000001);
        wait_run();
        repeat (110) @(posedge ref_clk);
        wr(OFS_CTRL, 32'h00000000);
        wait_st(6'h20);
        t0 = cyc;
        chk("brake_lvl", dc_level, 32'h00000028);
        wait_st(6'h01);
        chk("brake_len", (cyc - t0) inside {[85:115]}, 32'h00000001);
        // input-driven braking on a falling edge
        wr(OFS_DC_CFG, 32'h05011E28);
        di_pin <= 1'b1;
        repeat (5) @(posedge ref_clk);
        di_pin <= 1'b0;
        repeat (8) @(posedge ref_clk);
        chk("di_brake", dc_on, 32'h00000001);
        wait_st(6'h01);
        // reference direction with a zero reference
        wr(OFS_REF, 32'h00000000);
        wr(OFS_STOP_CFG, 32'h00000001);
        wr(OFS_START_CFG, 32'h00000405);
        wr(OFS_CTRL, 32'h00000003);
        repeat (3) @(posedge ref_clk);
        chk("zero_ref", freq_set, 32'h00000000);
        chk("zero_force", freq_force, 32'h00000001);
        chk("zero_volt", volt_set, 32'h00000100);
        wr(OFS_CTRL, 32'h00000000);
        wait_st(6'h01);
        // delay skipped, frequency jump, light load voltage cut
        wr(OFS_REF, 32'h00000064);
        wr(OFS_RESON, 32'h00000064);
        wr(OFS_START_FV, 32'h01000005);
        wr(OFS_STOP_CFG, 32'h0000010A);
        wr(OFS_START_CFG, 32'h00000305);
        wr(OFS_CTRL, 32'h00000001);
        repeat (4) @(posedge ref_clk);
        chk("skip_run", ramp_run, 32'h00000001);
        chk("jumps", jumps, 32'h00000001);
        chk("jump_f", jump_f, 32'h0000000A);
        chk("scale_idle", volt_scale, 32'h00000032);
        wr(OFS_RESON, 32'h00000000);
        load_pct <= 7'h28;
        repeat (4) @(posedge ref_clk);
        chk("scale_40", volt_scale, 32'h00000046);
        load_pct <= 7'h64;
        repeat (4) @(posedge ref_clk);
        summarize();
    end

    initial begin
        repeat (40000) @(posedge ref_clk);
        n_errors++;
        summarize();
    end
endmodule // start_stop_seq_bench
